// file: logic/bcida_pkg.sv
// Package for the bit clear, invert and decimal adjust datapath.
// Assumes a single core clock and a synchronous active-high reset.
package bcida_pkg;

    // Operation codes presented by the core's instruction decode
    typedef enum logic [2:0] {
        BCIDA_OP_NONE      = 3'h0,   // No operation this cycle
        BCIDA_OP_BIT_CLEAR = 3'h1,   // Clear one bit of a memory byte
        BCIDA_OP_WD_RESTART = 3'h2,  // Op watchdog_restart_op
        BCIDA_OP_INVERT    = 3'h3,   // Op bitwise_invert_op, in place
        BCIDA_OP_INV_WORK  = 3'h4,   // Op invert_into_working_op
        BCIDA_OP_DEC_ADJ   = 3'h5    // Op decimal_adjust_op
    } bcida_op_e;

    localparam int unsigned BCIDA_DATA_W   = 8;       // Byte width
    localparam int unsigned BCIDA_BIT_SEL_W = 3;      // Bit index width
    localparam int unsigned BCIDA_WD_W     = 8;       // Watchdog width

    // Decimal adjust constants
    localparam logic [3:0] BCIDA_NIBBLE_MAX = 4'h9;   // Largest BCD digit
    localparam logic [7:0] BCIDA_ADJ_NONE   = 8'h00;  // No correction
    localparam logic [7:0] BCIDA_ADJ_LOW    = 8'h06;  // Low digit fix
    localparam logic [7:0] BCIDA_ADJ_HIGH   = 8'h60;  // High digit fix
    localparam logic [7:0] BCIDA_ADJ_BOTH   = 8'h66;  // Both digits fix

    // Reset values
    localparam logic [7:0] BCIDA_BYTE_RST  = 8'h00;   // Data reset value
    localparam logic       BCIDA_FLAG_RST  = 1'b0;    // Flag reset value
    localparam logic       BCIDA_BIT_ZERO  = 1'b0;    // Cleared bit value

endpackage

// file: logic/bcida_dec_adj.sv
// Combinational decimal adjust unit for the working register.
// Assumes the flags reflect the last BCD addition made by the core.
`timescale 1ns/100ps
module bcida_dec_adj (
    input  wire logic [7:0] operand,     // Working register value
    input  wire logic       carry_in,    // Carry flag before adjust
    input  wire logic       half_in,     // Half-carry flag before adjust
    output logic      [7:0] adjust,      // Chosen correction constant
    output logic      [7:0] result,      // Adjusted BCD byte
    output logic            carry_out    // Carry flag after adjust
);
    import bcida_pkg::*;

    logic       fix_low;                 // Low digit needs +6
    logic       fix_high;                // High digit needs +6
    logic [8:0] sum;                     // Sum with overflow bit

    // Pick one of four constants; one add keeps the path short
    always_comb begin
        fix_low  = (operand[3:0] > BCIDA_NIBBLE_MAX) || half_in;
        fix_high = (operand[7:4] > BCIDA_NIBBLE_MAX) || carry_in;
        case ({fix_high, fix_low})
            2'h1:    adjust = BCIDA_ADJ_LOW;
            2'h2:    adjust = BCIDA_ADJ_HIGH;
            2'h3:    adjust = BCIDA_ADJ_BOTH;
            default: adjust = BCIDA_ADJ_NONE;
        endcase
        sum       = {1'b0, operand} + {1'b0, adjust};
        result    = sum[7:0];
        // Overflow marks a sum of 100 or more; never clears the carry
        carry_out = carry_in | sum[8];
    end

endmodule

// file: logic/bcida_core.sv
// Datapath for bit clear, watchdog restart, invert and decimal adjust.
// Assumes the core presents one operation a cycle with the addressed
// memory byte already read, and writes back on mem_we a cycle later.
//
// Behaviour
// - Bit clear zeroes one bit, flags untouched
// - Watchdog restart clears counter, expiry, power-down (a same-cycle sleep event keeps power-down set)
// - In-place invert complements byte, updates zero
// - Invert into working register, memory kept
// - Low digit above 9 or half-carry: +6
// - High digit above 9 or carry: +6
// - One add of 00/06/60/66; only carry changes
// - Adjust reads working register, writes memory
`timescale 1ns/100ps
module bcida_core #(
    parameter int unsigned WD_W = bcida_pkg::BCIDA_WD_W  // Watchdog width
) (
    input  wire logic                clk,          // Core clock, 40 MHz
    input  wire logic                sys_rst,      // Sync reset, high
    input  wire bcida_pkg::bcida_op_e op_code,     // Operation to run
    input  wire logic [2:0]          bit_sel,      // Bit index for clear
    input  wire logic [7:0]          mem_rdata,    // Addressed byte
    input  wire logic                acc_load,     // Core loads working
    input  wire logic [7:0]          acc_in,       // Working load value
    input  wire logic                flag_load,    // Core loads flags
    input  wire logic                carry_in,     // Carry load value
    input  wire logic                half_in,      // Half-carry load value
    input  wire logic                zero_in,      // Zero load value
    input  wire logic                wd_tick,      // Watchdog count enable
    input  wire logic                sleep_entry,  // Power-down event
    output logic                     mem_we,       // Memory write strobe
    output logic [7:0]               mem_wdata,    // Memory write data
    output logic                     op_done,      // Operation finished
    output logic [7:0]               working_register, // Accumulator
    output logic                     carry_flag,   // Carry flag
    output logic                     half_carry_flag, // Half-carry flag
    output logic                     zero_flag,    // Zero flag
    output logic                     expiry_flag,  // Watchdog expired
    output logic                     power_down_flag, // Power-down seen
    output logic [WD_W-1:0]          watchdog_counter // Watchdog count
);
    import bcida_pkg::*;

    // Every piece of state lives in one record
    typedef struct packed {
        logic            we;       // Write strobe
        logic [7:0]      wdata;    // Write data
        logic            done;     // Done pulse
        logic [7:0]      acc;      // Working register
        logic            carry;    // Carry flag
        logic            half;     // Half-carry flag
        logic            zero;     // Zero flag
        logic            expiry;   // Expiry flag
        logic            pdown;    // Power-down flag
        logic [WD_W-1:0] wd;       // Watchdog counter
    } bcida_state_s;

    bcida_state_s state;           // Registered state
    bcida_state_s next_state;      // Next state

    logic [7:0] adj_const;         // Chosen correction
    logic [7:0] adj_result;        // Adjusted byte
    logic       adj_carry;         // Carry after adjust
    logic [7:0] inv_byte;          // Complemented memory byte
    logic [7:0] clr_byte;          // Byte with one bit cleared

    // Mask with a single set bit; used only by the checks
    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        logic [7:0] m;
        m      = BCIDA_BYTE_RST;
        m[idx] = 1'b1;
        return m;
    endfunction

    // Decimal adjust works on the current working register
    bcida_dec_adj u_dec_adj (
        .operand   (state.acc),
        .carry_in  (state.carry),
        .half_in   (state.half),
        .adjust    (adj_const),
        .result    (adj_result),
        .carry_out (adj_carry)
    );

    // Next-state logic for all operations
    always_comb begin
        next_state       = state;
        next_state.we    = 1'b0;
        next_state.done  = 1'b0;
        inv_byte         = ~mem_rdata;
        clr_byte         = mem_rdata;
        clr_byte[bit_sel] = BCIDA_BIT_ZERO;
        // Core loads; an operation writing the same field in the same cycle overrides it
        if (acc_load) begin
            next_state.acc = acc_in;
        end
        if (flag_load) begin
            next_state.carry = carry_in;
            next_state.half  = half_in;
            next_state.zero  = zero_in;
        end
        // Watchdog counts on wd_tick; wrap raises expiry
        if (wd_tick) begin
            next_state.wd = state.wd + 1'b1;
            if (&state.wd) begin
                next_state.expiry = 1'b1;
            end
        end
        case (op_code)
            BCIDA_OP_BIT_CLEAR: begin
                next_state.we    = 1'b1;
                next_state.wdata = clr_byte;
                next_state.done  = 1'b1;
            end
            BCIDA_OP_WD_RESTART: begin
                next_state.wd     = '0;
                next_state.expiry = BCIDA_FLAG_RST;
                next_state.pdown  = BCIDA_FLAG_RST;
                next_state.done   = 1'b1;
            end
            BCIDA_OP_INVERT: begin
                next_state.we    = 1'b1;
                next_state.wdata = inv_byte;
                next_state.zero  = (inv_byte == BCIDA_BYTE_RST);
                next_state.done  = 1'b1;
            end
            BCIDA_OP_INV_WORK: begin
                next_state.acc  = inv_byte;
                next_state.zero = (inv_byte == BCIDA_BYTE_RST);
                next_state.done = 1'b1;
            end
            BCIDA_OP_DEC_ADJ: begin
                // Result goes to memory; working register untouched
                next_state.we    = 1'b1;
                next_state.wdata = adj_result;
                next_state.carry = adj_carry;
                next_state.half  = state.half;
                next_state.zero  = state.zero;
                next_state.acc   = state.acc;
                next_state.done  = 1'b1;
            end
            default: begin
                // No operation
            end
        endcase
        // A power-down event wins over a restart in the same cycle
        if (sleep_entry) begin
            next_state.pdown = 1'b1;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from flip-flops
    assign mem_we           = state.we;
    assign mem_wdata        = state.wdata;
    assign op_done          = state.done;
    assign working_register = state.acc;
    assign carry_flag       = state.carry;
    assign half_carry_flag  = state.half;
    assign zero_flag        = state.zero;
    assign expiry_flag      = state.expiry;
    assign power_down_flag  = state.pdown;
    assign watchdog_counter = state.wd;

    // Helper signals so checks sample plain signals only
    logic       is_clr;            // Bit clear this cycle
    logic       is_rst;            // Restart without sleep event
    logic       is_inv;            // In-place invert
    logic       is_invw;           // Invert into working register
    logic       is_adj;            // Decimal adjust
    logic [7:0] chk_clr;           // Expected cleared byte
    logic       chk_lowfix;        // Low digit correction needed
    logic [3:0] chk_lowsum;        // Expected low digit
    logic [8:0] chk_sum;           // Expected full sum
    logic       quiet_core;        // No core loads this cycle

    always_comb begin
        is_clr     = (op_code == BCIDA_OP_BIT_CLEAR);
        is_rst     = (op_code == BCIDA_OP_WD_RESTART) && !sleep_entry;
        is_inv     = (op_code == BCIDA_OP_INVERT);
        is_invw    = (op_code == BCIDA_OP_INV_WORK);
        is_adj     = (op_code == BCIDA_OP_DEC_ADJ);
        chk_clr    = mem_rdata & ~bit_mask(bit_sel);
        chk_lowfix = (state.acc[3:0] > BCIDA_NIBBLE_MAX) || state.half;
        chk_lowsum = state.acc[3:0]
                   + (chk_lowfix ? BCIDA_ADJ_LOW[3:0] : BCIDA_ADJ_NONE[3:0]);
        chk_sum    = {1'b0, state.acc} + {1'b0, adj_const};
        quiet_core = !acc_load && !flag_load;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_bit_clear_data: assert property (
        is_clr |=> mem_we && (mem_wdata == $past(chk_clr)))
        else $error("bit clear wrote wrong byte");
    a_bit_clear_flags: assert property (
        is_clr && quiet_core |=> $stable(carry_flag) && $stable(zero_flag)
            && $stable(half_carry_flag))
        else $error("bit clear changed a flag");
    a_restart_clears: assert property (
        is_rst |=> (watchdog_counter == '0) && !expiry_flag
            && !power_down_flag && !mem_we)
        else $error("watchdog restart did not clear");
    a_invert_place: assert property (
        is_inv |=> mem_we && (mem_wdata == ~$past(mem_rdata))
            && (zero_flag == ($past(mem_rdata) == ~BCIDA_BYTE_RST)))
        else $error("in-place invert wrong");
    a_invert_working: assert property (
        is_invw |=> !mem_we && (working_register == ~$past(mem_rdata))
            && (zero_flag == ($past(mem_rdata) == ~BCIDA_BYTE_RST)))
        else $error("invert into working register wrong");
    a_adjust_low: assert property (
        is_adj |=> mem_wdata[3:0] == $past(chk_lowsum))
        else $error("low digit correction wrong");
    a_adjust_high: assert property (
        is_adj && ((state.acc[7:4] > BCIDA_NIBBLE_MAX) || state.carry)
            |-> adj_const[7:4] == 4'h6)
        else $error("high digit correction missing");
    a_adjust_flags: assert property (
        is_adj && quiet_core |=> $stable(zero_flag)
            && $stable(half_carry_flag))
        else $error("decimal adjust changed another flag");
    a_adjust_target: assert property (
        is_adj && quiet_core |=> mem_we && $stable(working_register)
            && (mem_wdata == $past(chk_sum[7:0])))
        else $error("decimal adjust result misplaced");
    a_adjust_carry: assert property (
        is_adj |=> carry_flag == ($past(state.carry) | $past(chk_sum[8])))
        else $error("decimal adjust carry wrong");

    c_bit_clear: cover property (is_clr ##1 mem_we);
    c_restart:   cover property (is_rst && expiry_flag);
    c_inv_zero:  cover property (is_invw && mem_rdata == ~BCIDA_BYTE_RST);
    c_adj_carry: cover property (is_adj && chk_sum[8]);

endmodule

// file: sim/tb_bit_clear_invert_decimal_adjust.sv
// Self-checking bench for the bit clear, invert and decimal adjust datapath.
// Assumes bcida_core answers just after the edge that takes an op, one cycle after the bench drives it.
`timescale 1ns/100ps
module tb_bit_clear_invert_decimal_adjust;
    import bcida_pkg::*;

    localparam int unsigned WD_W = 3;  // Short watchdog so a wrap is quick

    logic            clk;              // Core clock
    logic            sys_rst;          // Sync reset
    bcida_op_e       op_code;          // Operation driven
    logic [2:0]      bit_sel;          // Bit index
    logic [7:0]      mem_rdata;        // Addressed byte
    logic            acc_load;         // Working load strobe
    logic [7:0]      acc_in;           // Working load value
    logic            flag_load;        // Flag load strobe
    logic            carry_in;         // Carry load value
    logic            half_in;          // Half-carry load value
    logic            zero_in;          // Zero load value
    logic            wd_tick;          // Watchdog count enable
    logic            sleep_entry;      // Power-down event
    logic            mem_we;           // Write strobe
    logic [7:0]      mem_wdata;        // Write data
    logic            op_done;          // Completion pulse
    logic [7:0]      working_register; // Accumulator
    logic            carry_flag;       // Carry
    logic            half_carry_flag;  // Half-carry
    logic            zero_flag;        // Zero
    logic            expiry_flag;      // Watchdog expired
    logic            power_down_flag;  // Power-down seen
    logic [WD_W-1:0] watchdog_counter; // Watchdog count
    int              error_cnt;        // Mismatches
    int              n_compared;       // Comparisons made

    bcida_core #(.WD_W(WD_W)) dut (
        .clk(clk), .sys_rst(sys_rst), .op_code(op_code),
        .bit_sel(bit_sel), .mem_rdata(mem_rdata), .acc_load(acc_load),
        .acc_in(acc_in), .flag_load(flag_load), .carry_in(carry_in),
        .half_in(half_in), .zero_in(zero_in), .wd_tick(wd_tick),
        .sleep_entry(sleep_entry), .mem_we(mem_we), .mem_wdata(mem_wdata),
        .op_done(op_done), .working_register(working_register),
        .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
        .zero_flag(zero_flag), .expiry_flag(expiry_flag),
        .power_down_flag(power_down_flag),
        .watchdog_counter(watchdog_counter)
    );

    // Clock generator, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Byte comparison; case inequality so unknowns never match
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Single-bit comparison
    task automatic cmp1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run, shared with the watchdog
    task automatic final_report;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Load working register and flags as the core would
    task automatic load(input logic [7:0] a, input logic c, h, z);
        @(posedge clk);
        acc_load <= 1'b1; acc_in <= a; flag_load <= 1'b1;
        carry_in <= c; half_in <= h; zero_in <= z;
        @(posedge clk);
        acc_load <= 1'b0; flag_load <= 1'b0;
    endtask

    // Present one op for one edge, then sample after the answer edge
    task automatic run_op(input bcida_op_e op, input logic [2:0] bs,
                          input logic [7:0] rd);
        @(posedge clk);
        op_code <= op; bit_sel <= bs; mem_rdata <= rd;
        @(posedge clk);
        op_code <= BCIDA_OP_NONE;
        #1;
        cmp1(op_done, 1'b1);
    endtask

    // Pulse the watchdog tick for n consecutive edges
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            wd_tick <= 1'b1;
        end
        @(posedge clk);
        wd_tick <= 1'b0;
        #1;
    endtask

    // Every bit index cleared from all-ones; flags must not move
    task automatic test_bit_clear;
        load(8'h3C, 1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            run_op(BCIDA_OP_BIT_CLEAR, 3'(i), 8'hFF);
            cmp1(mem_we, 1'b1);
            cmp8(mem_wdata, 8'hFF & ~(8'h01 << i));
            cmp1(carry_flag & half_carry_flag & zero_flag, 1'b1);
        end
    endtask

    // Wrap sets expiry, sleep sets power-down, restart clears all three
    task automatic test_restart;
        tick(7);
        cmp8({5'h00, watchdog_counter}, 8'h07);
        cmp1(expiry_flag, 1'b0);
        tick(4);
        cmp8({5'h00, watchdog_counter}, 8'h03);
        cmp1(expiry_flag, 1'b1);
        @(posedge clk);
        sleep_entry <= 1'b1;
        @(posedge clk);
        sleep_entry <= 1'b0;
        #1;
        cmp1(power_down_flag, 1'b1);
        run_op(BCIDA_OP_WD_RESTART, 3'h0, 8'h00);
        cmp8({5'h00, watchdog_counter}, 8'h00);
        cmp1(expiry_flag, 1'b0);
        cmp1(power_down_flag, 1'b0);
        cmp1(carry_flag, 1'b1);
    endtask

    // In-place and into-working inversions, both zero outcomes
    task automatic test_invert;
        load(8'h33, 1'b0, 1'b0, 1'b0);
        run_op(BCIDA_OP_INVERT, 3'h0, 8'hFF);
        cmp1(mem_we, 1'b1);
        cmp8(mem_wdata, 8'h00);
        cmp1(zero_flag, 1'b1);
        run_op(BCIDA_OP_INVERT, 3'h0, 8'h5A);
        cmp8(mem_wdata, 8'hA5);
        cmp1(zero_flag, 1'b0);
        cmp8(working_register, 8'h33);
        run_op(BCIDA_OP_INV_WORK, 3'h0, 8'h0F);
        cmp1(mem_we, 1'b0);
        cmp8(working_register, 8'hF0);
        cmp1(zero_flag, 1'b0);
        run_op(BCIDA_OP_INV_WORK, 3'h0, 8'hFF);
        cmp8(working_register, 8'h00);
        cmp1(zero_flag, 1'b1);
    endtask

    // One decimal adjust: result to memory, only carry may move
    task automatic dadj(input logic [7:0] a, input logic c, h,
                        input logic [7:0] res, input logic co);
        load(a, c, h, ~c);
        run_op(BCIDA_OP_DEC_ADJ, 3'h0, 8'h00);
        cmp1(mem_we, 1'b1);
        cmp8(mem_wdata, res);
        cmp1(carry_flag, co);
        cmp8(working_register, a);
        cmp1(half_carry_flag, h);
        cmp1(zero_flag, ~c);
    endtask

    // Main sequence
    initial begin
        error_cnt = 0; n_compared = 0;
        sys_rst = 1'b1; op_code = BCIDA_OP_NONE; bit_sel = 3'h0;
        mem_rdata = 8'h00; acc_load = 1'b0; acc_in = 8'h00;
        flag_load = 1'b0; carry_in = 1'b0; half_in = 1'b0;
        zero_in = 1'b0; wd_tick = 1'b0; sleep_entry = 1'b0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        cmp8(working_register, 8'h00);
        test_bit_clear();
        test_restart();
        test_invert();
        dadj(8'h12, 1'b0, 1'b0, 8'h12, 1'b0);
        dadj(8'h1C, 1'b0, 1'b0, 8'h22, 1'b0);
        dadj(8'h13, 1'b0, 1'b1, 8'h19, 1'b0);
        dadj(8'h8A, 1'b0, 1'b0, 8'h90, 1'b0);
        dadj(8'hA2, 1'b0, 1'b0, 8'h02, 1'b1);
        dadj(8'h25, 1'b1, 1'b0, 8'h85, 1'b1);
        dadj(8'hBB, 1'b0, 1'b0, 8'h21, 1'b1);
        dadj(8'h99, 1'b1, 1'b1, 8'hFF, 1'b1);
        final_report();
    end

    // Hang guard; the whole run needs well under a thousand cycles
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end

endmodule
